// >>> verilog/wdta_top.sv
/*
  watchdog timer with timed-access protection of its control bits, as a
  slave of the processor's special function register bus.
  assumes one-cycle write strobes and read strobes from the core on clk,
  and that event inputs come from logic on the same clock.
*/
`timescale 1ns/100ps
`include "wdta_regs.svh"

module wdta_top #(
  parameter int WARN_LEN_0 = 131072,     // select 00
  parameter int WARN_LEN_1 = 1048576,    // select 01
  parameter int WARN_LEN_2 = 8388608,    // select 10
  parameter int WARN_LEN_3 = 67108864,   // select 11
  parameter int CW         = 27          // counter width
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfrAddr,       // register address
  input  wire logic       sfrWrEn,       // one-cycle write strobe
  input  wire logic [7:0] sfrWrData,     // write data
  input  wire logic       sfrRdEn,       // one-cycle read strobe
  input  wire logic       powerOnEvent,  // power-on reset seen, pulse
  input  wire logic       pfiEvent,      // power-fail warning, pulse
  output logic      [7:0] sfrRdData,     // read data, one cycle later
  output logic            cpuResetReq,   // one-cycle reset request
  output logic            wdIrqReq,      // level interrupt request
  output logic            bandgapStopSel,
  output logic      [2:0] romSizeSel,
  output logic      [2:0] timerRateSel,
  output logic            pfiEnable
);

  localparam logic [7:0] WINDOW_CLOCKS = 8'(`WDTA_WINDOW_MCYCLES * `WDTA_CLOCKS_PER_MCYCLE);

  // register state
  logic [7:0] clockControl_r;            // select bits and timer rates
  logic [7:0] extIrqEnable_r;            // extended interrupt enable
  logic [7:1] extFlagsPlain_r;           // unprotected flag bits
  logic       bandgapStopSel_r;          // protected band-gap bit
  logic [2:0] internal_rom_size_r;                 // protected rom size select
  logic       wdcOther7_r;               // plain storage bit
  logic       pfiEnable_r;               // power-fail irq enable
  logic       pfiFlag_r;                 // power-fail flag
  logic       porFlag_r;                 // power-on reset flag
  logic       warnFlag_r;                // early warning flag
  logic       resetFlag_r;               // time-out reset flag
  logic       resetEnable_r;             // watchdog reset enable
  logic       restartReq_r;              // restart pulse to counter
  logic [7:0] rdData_r;                  // read data register
  logic       cpuReset_r;                // reset request register
  logic       irqReq_r;                  // interrupt request register

  // unlock gate state
  wdta_pkg::wdta_unlock_t unlock_r;
  wdta_pkg::wdta_unlock_t unlock_nxt;
  logic [7:0]             window_r;      // clocks left in open window

  // decoded strobes
  logic       wrTimed;                   // write to unlock register
  logic       wrWdc;                     // write to watchdog control
  logic       wrProtReg;                 // write to any protected reg
  logic       windowOpen;                // protected writes allowed
  logic [CW-1:0] warnLen;                // selected warning length
  logic       warnHit;
  logic       fullHit;
  logic [7:0] wdcRead;                   // assembled control value
  logic [7:0] exifRead;                  // assembled flags value

  assign wrTimed    = sfrWrEn && (sfrAddr == `WDTA_ADDR_TIMED_ACCESS);
  assign wrWdc      = sfrWrEn && (sfrAddr == `WDTA_ADDR_WATCHDOG_CTRL);
  assign wrProtReg  = wrWdc
                   || (sfrWrEn && (sfrAddr == `WDTA_ADDR_EXT_IRQ_FLAGS))
                   || (sfrWrEn && (sfrAddr == `WDTA_ADDR_ROM_SIZE));
  assign windowOpen = (unlock_r == wdta_pkg::WDTA_OPEN);

  // time-out length from the two select bits
  always_comb begin
    unique case (clockControl_r[`WDTA_CKC_SEL_HI:`WDTA_CKC_SEL_LO])
      2'b00: warnLen = CW'(WARN_LEN_0);
      2'b01: warnLen = CW'(WARN_LEN_1);
      2'b10: warnLen = CW'(WARN_LEN_2);
      2'b11: warnLen = CW'(WARN_LEN_3);
    endcase
  end

  // counter runs on the crystal clock with no enable of its own
  wdta_counter #(
    .CW      (CW)
  ) u_counter (
    .clk     (clk),
    .rst_n   (rst_n),
    .restart (restartReq_r),
    .warnLen (warnLen),
    .warnHit (warnHit),
    .fullHit (fullHit)
  );

  // unlock sequence: any stray write breaks a half-entered key
  always_comb begin
    unlock_nxt = unlock_r;
    unique case (unlock_r)
      wdta_pkg::WDTA_LOCKED: begin
        if (wrTimed && sfrWrData == `WDTA_KEY_FIRST) begin
          unlock_nxt = wdta_pkg::WDTA_HALF_KEY;
        end
      end
      wdta_pkg::WDTA_HALF_KEY: begin
        if (wrTimed && sfrWrData == `WDTA_KEY_SECOND) begin
          unlock_nxt = wdta_pkg::WDTA_OPEN;
        end else if (wrTimed && sfrWrData == `WDTA_KEY_FIRST) begin
          unlock_nxt = wdta_pkg::WDTA_HALF_KEY;
        end else if (sfrWrEn) begin
          unlock_nxt = wdta_pkg::WDTA_LOCKED;
        end
      end
      wdta_pkg::WDTA_OPEN: begin
        if (wrTimed && sfrWrData == `WDTA_KEY_FIRST) begin
          unlock_nxt = wdta_pkg::WDTA_HALF_KEY;
        end else if (wrProtReg || wrTimed) begin
          unlock_nxt = wdta_pkg::WDTA_LOCKED;
        end else if (window_r == 8'h01) begin
          unlock_nxt = wdta_pkg::WDTA_LOCKED;
        end
      end
      default: begin
        unlock_nxt = wdta_pkg::WDTA_LOCKED; // unused code recovers
      end
    endcase
  end

  // unlock state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unlock_r <= wdta_pkg::WDTA_LOCKED;
    end else begin
      unlock_r <= unlock_nxt;
    end
  end

  // window length counts crystal clocks of three machine cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      window_r <= 8'h00;
    end else if (unlock_r == wdta_pkg::WDTA_HALF_KEY
                 && unlock_nxt == wdta_pkg::WDTA_OPEN) begin
      window_r <= WINDOW_CLOCKS;
    end else if (windowOpen && window_r != 8'h00) begin
      window_r <= window_r - 8'h01;
    end
  end

  // plain read-write registers outside the protection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clockControl_r  <= `WDTA_RST_CLOCK_CONTROL;
      extIrqEnable_r  <= `WDTA_RST_EXT_IRQ_ENABLE;
      extFlagsPlain_r <= 7'(`WDTA_RST_EXT_IRQ_FLAGS >> 1);
      wdcOther7_r     <= 1'b0;
      pfiEnable_r     <= 1'b0;
    end else begin
      if (sfrWrEn && sfrAddr == `WDTA_ADDR_CLOCK_CONTROL) begin
        clockControl_r <= sfrWrData;
      end
      if (sfrWrEn && sfrAddr == `WDTA_ADDR_EXT_IRQ_ENABLE) begin
        extIrqEnable_r <= sfrWrData;
      end
      if (sfrWrEn && sfrAddr == `WDTA_ADDR_EXT_IRQ_FLAGS) begin
        extFlagsPlain_r <= sfrWrData[7:1];
      end
      if (wrWdc) begin
        wdcOther7_r <= sfrWrData[7];
        pfiEnable_r <= sfrWrData[`WDTA_WDC_PFI_ENABLE];
      end
    end
  end

  // protected band-gap and rom size bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bandgapStopSel_r <= 1'b0;
      internal_rom_size_r        <= `WDTA_RST_ROM_SIZE;
    end else if (windowOpen) begin
      if (sfrWrEn && sfrAddr == `WDTA_ADDR_EXT_IRQ_FLAGS) begin
        bandgapStopSel_r <= sfrWrData[`WDTA_EXTENDED_INTERRUPT_FLAGS_BANDGAP];
      end
      if (sfrWrEn && sfrAddr == `WDTA_ADDR_ROM_SIZE) begin
        internal_rom_size_r <= sfrWrData[`WDTA_ROM_SIZE_HI:0];
      end
    end
  end

  // protected enable and restart; restart is a pulse and reads as zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resetEnable_r <= 1'b0;
      restartReq_r  <= 1'b0;
    end else begin
      restartReq_r <= wrWdc && windowOpen && sfrWrData[`WDTA_WDC_RESTART];
      if (wrWdc && windowOpen) begin
        resetEnable_r <= sfrWrData[`WDTA_WDC_RESET_ENABLE];
      end
    end
  end

  // warning flag: hardware set wins over a protected software write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      warnFlag_r <= 1'b0;
    end else if (warnHit) begin
      warnFlag_r <= 1'b1;
    end else if (wrWdc && windowOpen) begin
      warnFlag_r <= sfrWrData[`WDTA_WDC_WARN_FLAG];
    end
  end

  // reset flag is not protected, so software may clear it freely
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resetFlag_r <= 1'b0;
    end else if (fullHit) begin
      resetFlag_r <= 1'b1;
    end else if (wrWdc) begin
      resetFlag_r <= sfrWrData[`WDTA_WDC_RESET_FLAG];
    end
  end

  // power-on flag is protected; power-fail flag is not
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      porFlag_r <= 1'b0;
      pfiFlag_r <= 1'b0;
    end else begin
      if (powerOnEvent) begin
        porFlag_r <= 1'b1;
      end else if (wrWdc && windowOpen) begin
        porFlag_r <= sfrWrData[`WDTA_WDC_POR_FLAG];
      end
      if (pfiEvent) begin
        pfiFlag_r <= 1'b1;
      end else if (wrWdc) begin
        pfiFlag_r <= sfrWrData[`WDTA_WDC_PFI_FLAG];
      end
    end
  end

  // request outputs; the interrupt is a level so it can wake a halted core
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuReset_r <= 1'b0;
      irqReq_r   <= 1'b0;
    end else begin
      cpuReset_r <= fullHit && resetEnable_r;
      irqReq_r   <= warnFlag_r && extIrqEnable_r[`WDTA_EIE_WARN_IRQ_EN];
    end
  end

  // read views; restart always reads zero
  assign wdcRead  = {wdcOther7_r, porFlag_r, pfiEnable_r, pfiFlag_r,
                     warnFlag_r, resetFlag_r, resetEnable_r, 1'b0};
  assign exifRead = {extFlagsPlain_r, bandgapStopSel_r};

  // registered read, unmapped and write-only addresses read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_r <= `WDTA_RD_ZERO;
    end else if (sfrRdEn) begin
      unique case (sfrAddr)
        `WDTA_ADDR_CLOCK_CONTROL:  rdData_r <= clockControl_r;
        `WDTA_ADDR_EXT_IRQ_FLAGS:  rdData_r <= exifRead;
        `WDTA_ADDR_ROM_SIZE:       rdData_r <= {5'h00, internal_rom_size_r};
        `WDTA_ADDR_WATCHDOG_CTRL:  rdData_r <= wdcRead;
        `WDTA_ADDR_EXT_IRQ_ENABLE: rdData_r <= extIrqEnable_r;
        default:                   rdData_r <= `WDTA_RD_ZERO;
      endcase
    end
  end

  // outputs straight from flip-flops
  assign sfrRdData      = rdData_r;
  assign cpuResetReq    = cpuReset_r;
  assign wdIrqReq       = irqReq_r;
  assign bandgapStopSel = bandgapStopSel_r;
  assign romSizeSel     = internal_rom_size_r;
  assign timerRateSel   = clockControl_r[`WDTA_CKC_RATE_HI:`WDTA_CKC_RATE_LO];
  assign pfiEnable      = pfiEnable_r;

endmodule

// >>> verilog/wdta_regs.svh
/*
  register offsets, field positions, reset values and timing counts of the
  watchdog with timed-access gate.
  assumes an 8-bit special function register bus with byte addresses.
*/
`ifndef WDTA_REGS_SVH
`define WDTA_REGS_SVH

// register addresses on the special function register bus
`define WDTA_ADDR_CLOCK_CONTROL   8'h8E
`define WDTA_ADDR_EXT_IRQ_FLAGS   8'h91
`define WDTA_ADDR_ROM_SIZE        8'hC2
`define WDTA_ADDR_TIMED_ACCESS    8'hC7
`define WDTA_ADDR_WATCHDOG_CTRL   8'hD8
`define WDTA_ADDR_EXT_IRQ_ENABLE  8'hE8

// clock control fields
`define WDTA_CKC_SEL_HI           7
`define WDTA_CKC_SEL_LO           6
`define WDTA_CKC_RATE_HI          5
`define WDTA_CKC_RATE_LO          3

// watchdog control fields
`define WDTA_WDC_POR_FLAG         6
`define WDTA_WDC_PFI_ENABLE       5
`define WDTA_WDC_PFI_FLAG         4
`define WDTA_WDC_WARN_FLAG        3
`define WDTA_WDC_RESET_FLAG       2
`define WDTA_WDC_RESET_ENABLE     1
`define WDTA_WDC_RESTART          0

// other fields
`define WDTA_EIE_WARN_IRQ_EN      4
`define WDTA_EXTENDED_INTERRUPT_FLAGS_BANDGAP         0
`define WDTA_ROM_SIZE_HI          2

// reset values
`define WDTA_RST_CLOCK_CONTROL    8'h00
`define WDTA_RST_WATCHDOG_CTRL    8'h00
`define WDTA_RST_EXT_IRQ_ENABLE   8'h00
`define WDTA_RST_EXT_IRQ_FLAGS    8'h00
`define WDTA_RST_ROM_SIZE         3'h5
`define WDTA_RD_ZERO              8'h00

// unlock keys
`define WDTA_KEY_FIRST            8'hAA
`define WDTA_KEY_SECOND           8'h55

// timing: clocks between warning and reset, window in machine cycles
`define WDTA_GAP_CLOCKS           10'h200
`define WDTA_WINDOW_MCYCLES       4'h3
`define WDTA_CLOCKS_PER_MCYCLE    4'h4

`endif

// >>> verilog/wdta_pkg.sv
/*
  types shared by the watchdog with timed-access gate.
  assumes wdta_regs.svh supplies all numeric constants.
*/
package wdta_pkg;

  // unlock sequence state
  typedef enum logic [1:0] {
    WDTA_LOCKED   = 2'b00,  // waiting for first key
    WDTA_HALF_KEY = 2'b01,  // first key seen
    WDTA_OPEN     = 2'b10   // protected writes allowed
  } wdta_unlock_t;

endpackage

// >>> verilog/wdta_counter.sv
/*
  free-running watchdog counter: warning pulse at the interrupt length,
  full time-out pulse a fixed gap later, then it wraps and keeps counting.
  assumes lengths are stable or change only between intervals.
*/
`timescale 1ns/100ps
`include "wdta_regs.svh"

module wdta_counter #(
  parameter int CW = 27                  // wide enough for 2^26 + gap
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          restart,    // start a full new interval
  input  wire logic [CW-1:0] warnLen,    // clocks to the warning
  output logic               warnHit,    // one-cycle pulse
  output logic               fullHit     // one-cycle pulse
);

  logic [CW-1:0] count_r;                // clocks since interval start
  logic [CW-1:0] fullLen;                // warning plus gap

  assign fullLen = warnLen + CW'(`WDTA_GAP_CLOCKS);

  // no run enable exists: the count advances every clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (restart) begin
      count_r <= '0;
    end else if (count_r == fullLen - CW'(1)) begin
      count_r <= '0;
    end else begin
      count_r <= count_r + CW'(1);
    end
  end

  // hit pulses, registered so they line up with the flag update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      warnHit <= 1'b0;
      fullHit <= 1'b0;
    end else begin
      warnHit <= !restart && (count_r == warnLen - CW'(1));
      fullHit <= !restart && (count_r == fullLen - CW'(1));
    end
  end

endmodule

// >>> verif/wdta_checker.sv
/*
  assertion checker for the watchdog with timed-access gate.
  assumes it is bound to wdta_top and sees only that module's ports.
*/
`timescale 1ns/100ps
`include "wdta_regs.svh"
module wdta_checker #(
  parameter int WARN_LEN_0 = 64,
  parameter int WARN_LEN_1 = 128,
  parameter int WARN_LEN_2 = 256,
  parameter int WARN_LEN_3 = 1024
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] sfrAddr,
  input wire logic       sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic       sfrRdEn,
  input wire logic       powerOnEvent,
  input wire logic       pfiEvent,
  input wire logic [7:0] sfrRdData,
  input wire logic       cpuResetReq,
  input wire logic       wdIrqReq,
  input wire logic       bandgapStopSel,
  input wire logic [2:0] romSizeSel,
  input wire logic [2:0] timerRateSel,
  input wire logic       pfiEnable
);
  logic        key_r;        // first key seen
  logic [2:0]  rate_r;       // shadow of timer rate field
  logic [3:0]  win_r;        // open-window clocks left
  logic        rstEn_r;      // shadow of reset enable
  logic        irqEn_r;      // shadow of irq enable
  logic        d8Wr_r;       // control write in the last cycle
  logic        armed_r;      // restart with warning cleared seen
  logic [1:0]  sel_r;        // shadow of time-out select
  logic [11:0] since_r;      // clocks since accepted control write
  int          selLen;       // warning length for sel_r
  wire taWr = sfrWrEn && sfrAddr == `WDTA_ADDR_TIMED_ACCESS;
  wire d8Wr = sfrWrEn && sfrAddr == `WDTA_ADDR_WATCHDOG_CTRL;
  wire c2Wr = sfrWrEn && sfrAddr == `WDTA_ADDR_ROM_SIZE;
  wire prWr = d8Wr || c2Wr || (sfrWrEn && sfrAddr == `WDTA_ADDR_EXT_IRQ_FLAGS);
  wire c2Ok = c2Wr && win_r != 4'h0;
  wire d8Ok = d8Wr && win_r != 4'h0;
  // band-gap write that the open window lets through
  wire bgOk = sfrWrEn && sfrAddr == `WDTA_ADDR_EXT_IRQ_FLAGS && win_r != 4'h0;
  always_comb begin
    case (sel_r)
      2'h0:    selLen = WARN_LEN_0;
      2'h1:    selLen = WARN_LEN_1;
      2'h2:    selLen = WARN_LEN_2;
      default: selLen = WARN_LEN_3;
    endcase
  end
  // any write other than the first key drops a half-entered key
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) key_r <= 1'b0;
    else if (sfrWrEn) key_r <= taWr && sfrWrData == `WDTA_KEY_FIRST;
  end
  // window: 12 clocks, closed early by a protected or key write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) win_r <= 4'h0;
    else if (taWr && key_r && sfrWrData == `WDTA_KEY_SECOND) win_r <= 4'hC;
    else if (taWr || prWr) win_r <= 4'h0;
    else if (win_r != 4'h0) win_r <= win_r - 4'h1;
  end
  // register shadows taken from accepted writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {rstEn_r, irqEn_r, d8Wr_r, sel_r} <= 5'h00;
      rate_r <= 3'h0;
    end else begin
      d8Wr_r <= d8Wr;
      if (d8Ok) rstEn_r <= sfrWrData[1];
      if (sfrWrEn && sfrAddr == `WDTA_ADDR_EXT_IRQ_ENABLE) irqEn_r <= sfrWrData[4];
      if (sfrWrEn && sfrAddr == `WDTA_ADDR_CLOCK_CONTROL) sel_r <= sfrWrData[7:6];
      if (sfrWrEn && sfrAddr == `WDTA_ADDR_CLOCK_CONTROL) rate_r <= sfrWrData[5:3];
    end
  end
  // restart age; disarmed by an irq enable write or a reset request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_r <= 1'b0;
      since_r <= 12'h000;
    end else if (d8Ok) begin
      armed_r <= sfrWrData[0] && !sfrWrData[3];
      since_r <= 12'h000;
    end else begin
      if (cpuResetReq || (sfrWrEn && sfrAddr == `WDTA_ADDR_EXT_IRQ_ENABLE)) armed_r <= 1'b0;
      if (since_r != 12'hFFF) since_r <= since_r + 12'h001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_warn_count: assert property (
    $rose(wdIrqReq) && armed_r |-> int'(since_r) == selLen + 3) else $error("warning late");
  a_reset_gap: assert property (
    cpuResetReq && armed_r |-> $past(wdIrqReq, 511) && !$past(wdIrqReq, 512))
    else $error("reset gap wrong");
  a_reset_enable: assert property (
    cpuResetReq |-> $past(rstEn_r)) else $error("reset while disabled");
  a_reset_pulse: assert property (
    cpuResetReq |=> !cpuResetReq) else $error("reset pulse too long");
  a_irq_gate: assert property (
    wdIrqReq |-> $past(irqEn_r)) else $error("irq while disabled");
  a_irq_holds: assert property (
    wdIrqReq && irqEn_r && !d8Wr_r |=> wdIrqReq) else $error("irq dropped");
  a_unlock_reads: assert property (
    sfrRdEn && sfrAddr == `WDTA_ADDR_TIMED_ACCESS |=> sfrRdData == `WDTA_RD_ZERO)
    else $error("unlock register readable");
  a_restart_reads: assert property (
    sfrRdEn && sfrAddr == `WDTA_ADDR_WATCHDOG_CTRL |=> !sfrRdData[0])
    else $error("restart bit reads one");
  a_rom_guard: assert property (
    $changed(romSizeSel) |-> $past(c2Ok) || $past(c2Ok, 2)) else $error("rom size unguarded");
  c_cpu_reset: cover property (cpuResetReq);
  c_warn_rise: cover property ($rose(wdIrqReq) && armed_r);
  a_bandgap_guard: assert property (
    $changed(bandgapStopSel) |-> $past(bgOk)) else $error("band-gap unguarded");
  a_rate_follows: assert property (
    sfrWrEn && sfrAddr == `WDTA_ADDR_CLOCK_CONTROL |=> timerRateSel == rate_r)
    else $error("timer rate not stored");
  c_rom_write: cover property (c2Ok);
  c_por_event: cover property (powerOnEvent);
  c_pfi_event: cover property (pfiEvent && pfiEnable);
endmodule

bind wdta_top wdta_checker #(.WARN_LEN_0(WARN_LEN_0), .WARN_LEN_1(WARN_LEN_1),
  .WARN_LEN_2(WARN_LEN_2), .WARN_LEN_3(WARN_LEN_3)) u_checker (
  .clk(clk), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
  .sfrRdEn(sfrRdEn), .powerOnEvent(powerOnEvent), .pfiEvent(pfiEvent),
  .sfrRdData(sfrRdData), .cpuResetReq(cpuResetReq), .wdIrqReq(wdIrqReq),
  .bandgapStopSel(bandgapStopSel), .romSizeSel(romSizeSel),
  .timerRateSel(timerRateSel), .pfiEnable(pfiEnable));

// >>> verif/wdta_core_model.sv
/*
  processor core model: drives the register bus and the event inputs.
  assumes one strobe at a time, launched just after a clk edge.
*/
`timescale 1ns/100ps
module wdta_core_model (
  input  wire logic       clk,
  output logic      [7:0] sfrAddr,
  output logic            sfrWrEn,
  output logic      [7:0] sfrWrData,
  output logic            sfrRdEn,
  output logic            powerOnEvent,
  output logic            pfiEvent,
  input  wire logic [7:0] sfrRdData,
  input  wire logic       cpuResetReq
);
  int resetCount = 0;  // reset requests acted on
  // bus idle with strobes low
  initial begin
    sfrAddr = 8'h00;
    sfrWrData = 8'h00;
    {sfrWrEn, sfrRdEn, powerOnEvent, pfiEvent} = 4'h0;
  end
  always @(posedge clk) begin
    if (cpuResetReq === 1'b1) resetCount++;
  end
  // released lines show the inverse so stale values cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfrAddr <= a;
    sfrWrData <= d;
    sfrWrEn <= 1'b1;
    @(posedge clk);
    sfrWrEn <= 1'b0;
    sfrAddr <= ~a;
    sfrWrData <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfrAddr <= a;
    sfrRdEn <= 1'b1;
    @(posedge clk);
    sfrRdEn <= 1'b0;
    sfrAddr <= ~a;
    #1;
    d = sfrRdData;
  endtask
  task automatic unlock();
    wr(8'hC7, 8'hAA);
    wr(8'hC7, 8'h55);
  endtask
  // restart within the interval, as watchdog-aware code must
  task automatic kick(input logic [7:0] d);
    unlock();
    wr(8'hD8, d);
  endtask
  task automatic pulse(input logic por);
    @(posedge clk);
    powerOnEvent <= por;
    pfiEvent <= !por;
    @(posedge clk);
    powerOnEvent <= 1'b0;
    pfiEvent <= 1'b0;
  endtask
endmodule

// >>> verif/wdta_top_tb.sv
/*
  self-checking bench for the watchdog with timed-access gate.
  assumes the core model drives the bus and the checker is bound.
*/
`timescale 1ns/100ps
module wdta_top_tb;
  localparam int LEN [4] = '{64, 128, 256, 1024};  // shortened lengths
  logic       clk, rst_n, sfrWrEn, sfrRdEn, powerOnEvent, pfiEvent;
  logic       cpuResetReq, wdIrqReq, bandgapStopSel, pfiEnable;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData;
  logic [2:0] romSizeSel, timerRateSel;
  int         miscompares = 0;
  int         cmp_count = 0;
  int         n;
  wdta_top #(.WARN_LEN_0(LEN[0]), .WARN_LEN_1(LEN[1]), .WARN_LEN_2(LEN[2]),
    .WARN_LEN_3(LEN[3])) DUT (.clk(clk), .rst_n(rst_n), .sfrAddr(sfrAddr),
    .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn),
    .powerOnEvent(powerOnEvent), .pfiEvent(pfiEvent), .sfrRdData(sfrRdData),
    .cpuResetReq(cpuResetReq), .wdIrqReq(wdIrqReq), .bandgapStopSel(bandgapStopSel),
    .romSizeSel(romSizeSel), .timerRateSel(timerRateSel), .pfiEnable(pfiEnable));
  wdta_core_model core (.clk(clk), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
    .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .powerOnEvent(powerOnEvent),
    .pfiEvent(pfiEvent), .sfrRdData(sfrRdData), .cpuResetReq(cpuResetReq));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    core.rd(a, d);
    check(d, exp);
  endtask
  // clocks until irq or reset request shows; a hang ends the run
  task automatic cyclesTo(input logic rstReq, output int k);
    for (k = 1; k <= 3000; k++) begin
      @(posedge clk);
      #1;
      if ((rstReq ? cpuResetReq : wdIrqReq) === 1'b1) return;
    end
    miscompares++;
    complete_run();
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    core.wr(8'h8E, 8'hC0);
    rdChk(8'h8E, 8'hC0);
    rdChk(8'hC7, 8'h00);
    rdChk(8'h80, 8'h00);
    check(romSizeSel, 3'h5);
    // locked: protected bits refused, plain bits and events land
    core.wr(8'hD8, 8'h2B);
    core.wr(8'hC2, 8'h02);
    core.wr(8'h91, 8'h03);
    core.pulse(1'b1);
    core.pulse(1'b0);
    rdChk(8'hD8, 8'h70);
    rdChk(8'h91, 8'h02);
    check(romSizeSel, 3'h5);
    check(pfiEnable, 1'b1);
    // one protected write per unlock
    core.unlock();
    core.wr(8'hD8, 8'h10);
    core.wr(8'h91, 8'h03);
    rdChk(8'hD8, 8'h10);
    rdChk(8'h91, 8'h02);
    // key broken by another write, then re-armed by a second first key
    core.wr(8'hC7, 8'hAA);
    core.wr(8'h8E, 8'hC0);
    core.wr(8'hC7, 8'h55);
    core.wr(8'hC2, 8'h07);
    rdChk(8'hC2, 8'h05);
    core.wr(8'hC7, 8'hAA);
    core.unlock();
    core.wr(8'hC2, 8'h02);
    rdChk(8'hC2, 8'h02);
    check(romSizeSel, 3'h2);
    // window runs out before the write
    core.unlock();
    repeat (20) @(posedge clk);
    core.wr(8'h91, 8'h03);
    rdChk(8'h91, 8'h02);
    core.unlock();
    core.wr(8'h91, 8'h03);
    rdChk(8'h91, 8'h03);
    check(bandgapStopSel, 1'b1);
    // every select: warning, then reset request 511 clocks on
    for (int s = 0; s < 4; s++) begin
      core.wr(8'hE8, 8'h10);
      core.wr(8'h8E, {s[1:0], 6'h00});
      core.kick(8'h03);
      cyclesTo(1'b0, n);
      check(n, LEN[s] + 3);
      cyclesTo(1'b1, n);
      check(n, 511);
      rdChk(8'hD8, 8'h0E);
    end
    core.wr(8'hE8, 8'h00);
    @(posedge clk);
    #1;
    check(wdIrqReq, 1'b0);
    // reset disabled: flags still set, no reset request
    core.wr(8'h8E, 8'h38);
    core.kick(8'h01);
    n = core.resetCount;
    repeat (LEN[0] + 600) @(posedge clk);
    check(core.resetCount, n);
    rdChk(8'hD8, 8'h0C);
    check(timerRateSel, 3'h7);
    // restarts inside the interval keep reset away
    core.kick(8'h03);
    repeat (6) begin
      repeat (40) @(posedge clk);
      core.kick(8'h03);
    end
    check(core.resetCount, n);
    rdChk(8'hD8, 8'h02);
    // second reset mid-run, then free running with no enable
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdChk(8'hE8, 8'h00);
    rdChk(8'h8E, 8'h00);
    repeat (LEN[0] + 20) @(posedge clk);
    rdChk(8'hD8, 8'h08);
    complete_run();
  end
endmodule
